//--- src/rsc_map.svh
// Register map, field positions and timing counts of the reset controller
`ifndef RSC_MAP_SVH
`define RSC_MAP_SVH

`define RSC_ADDR_MON_CTRL     8'hff
`define RSC_ADDR_CAUSE        8'hef

`define RSC_MON_EN_BIT        7
`define RSC_MON_STAT_BIT      6

`define RSC_CAUSE_PIN_BIT     0
`define RSC_CAUSE_POR_BIT     1
`define RSC_CAUSE_MCD_BIT     2
`define RSC_CAUSE_WDT_BIT     3
`define RSC_CAUSE_SW_BIT      4
`define RSC_CAUSE_CMP_BIT     5
`define RSC_CAUSE_FLASH_BIT   6

`define RSC_CAUSE_RST_VAL     8'h02
`define RSC_USER_TOP_ADDR     16'h3dff

`define RSC_CLK_PERIOD_PS     8000
`define RSC_CLK_LOSS_TIME_US  100
`define RSC_CLK_LOSS_CYC      ((`RSC_CLK_LOSS_TIME_US * 1000000) / `RSC_CLK_PERIOD_PS)
`define RSC_SETTLE_CYC        64
`define RSC_HOLD_CYC          4

`endif

//--- src/rsc_pkg.sv
// Types shared by the reset controller files
`include "rsc_map.svh"
package rsc_pkg;

  // Register bus request from the core
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rsc_sfr_req_t;

  // Flash access observation from the memory controller
  typedef struct packed {
    logic        wr_valid;
    logic        wr_enable;
    logic [15:0] wr_addr;
    logic        code_rd_valid;
    logic [15:0] code_rd_addr;
    logic        fetch_valid;
    logic [15:0] fetch_addr;
    logic        sec_block;
  } rsc_flash_t;

  // Reset request sources, one bit each
  typedef struct packed {
    logic flash;
    logic cmp;
    logic sw;
    logic wdt;
    logic clock_loss_detector;
    logic vdm;
    logic pin;
  } rsc_req_t;

  typedef enum logic [2:0] {
    ST_POR  = 3'b001,
    ST_RUN  = 3'b010,
    ST_HOLD = 3'b100
  } rsc_state_t;

  // Address beyond the user code space
  function automatic logic rsc_above_user(input logic [15:0] addr);
    rsc_above_user = (addr > `RSC_USER_TOP_ADDR);
  endfunction : rsc_above_user

endpackage : rsc_pkg

//--- src/rsc_clock_loss.sv
// One-shot clock loss timer watching the sampled system clock level
`timescale 1ns/10ps
module rsc_clock_loss #(
  parameter int LIMIT_CYC = 12500,
  parameter int CNT_W     = 14
) (
  input  wire logic clk,        // Free-running reference clock
  input  wire logic nrst,       // Asynchronous reset, active low
  input  wire logic enable,     // Detector enable
  input  wire logic clk_level,  // Sampled level of the watched clock
  output logic      timeout     // One-cycle pulse on stuck clock
);

  logic [CNT_W-1:0] cnt_r;
  logic             level_r;
  logic             fired_r;
  logic             stuck;

  assign stuck = (clk_level == level_r);

  // Remember last level so any edge retriggers the one-shot
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      level_r <= 1'b0;
    else
      level_r <= clk_level;
  end

  // Count cycles without an edge; fires once past the limit
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_r   <= '0;
      fired_r <= 1'b0;
    end
    else if (!enable || !stuck)
    begin
      cnt_r   <= '0;
      fired_r <= 1'b0;
    end
    else if (cnt_r < CNT_W'(LIMIT_CYC))
      cnt_r <= cnt_r + CNT_W'(1);
    else
      fired_r <= 1'b1;
  end

  // Strictly longer than the limit, one pulse per stuck period
  assign timeout = enable && stuck && !fired_r
                   && (cnt_r == CNT_W'(LIMIT_CYC));

endmodule : rsc_clock_loss

//--- src/rsc_top.sv
// Reset source controller: merges reset requests and records the cause
`timescale 1ns/10ps
`include "rsc_map.svh"
module rsc_top #(
  parameter int CLK_LOSS_CYC = `RSC_CLK_LOSS_CYC,
  parameter int SETTLE_CYC   = `RSC_SETTLE_CYC,
  parameter int HOLD_CYC     = `RSC_HOLD_CYC
) (
  input  wire logic                 clk,            // System clock
  input  wire logic                 nrst,           // Power-on reset, low
  input  wire rsc_pkg::rsc_sfr_req_t sfr_req,       // Register access
  output logic [7:0]                sfr_rdata,      // Registered read data
  input  wire logic                 rst_pin_i,      // Reset pin level
  output logic                      rst_pin_o,      // Pin drive value
  output logic                      rst_pin_oe,     // Pin drive enable
  input  wire logic                 supply_mon_out, // Raw monitor output
  output logic                      supply_monitor_enable, // Analog on
  input  wire logic                 cmp_out,        // Comparator output
  input  wire logic                 wdt_expire,     // Watchdog overflow
  input  wire rsc_pkg::rsc_flash_t  flash,          // Flash accesses
  input  wire logic                 sys_clk_level,  // Watched clock level
  output logic                      sys_rst_n,      // System reset, low
  output logic [7:0]                reset_cause     // Cause flags
);

  // Limitations: the power-on delay, the watchdog's own timer and the
  // comparator live outside and arrive here as plain levels or pulses.
  // Selects cannot be read back, since the cause register shows flags
  // at the same positions, and software cannot clear a flag.
  // Two requests in one cycle both leave their flag set.

  localparam int SET_W  = $clog2(SETTLE_CYC + 1);
  localparam int HOLD_W = $clog2(HOLD_CYC + 1);
  localparam int LOSS_W = $clog2(CLK_LOSS_CYC + 1);

  rsc_pkg::rsc_state_t state_r;
  rsc_pkg::rsc_state_t state_nxt;
  rsc_pkg::rsc_req_t   req;

  logic              mon_en_r;
  logic [SET_W-1:0]  settle_r;
  logic              mon_settled;
  logic              mon_ok;
  logic              sel_vdm_r;
  logic              sel_mcd_r;
  logic              sel_cmp_r;
  logic [HOLD_W-1:0] hold_r;
  logic              hold_done;
  logic [7:0]        cause_r;
  logic [7:0]        req_bits;
  logic              power_cause;
  logic              any_req;
  logic              level_req;
  logic              pin_drive_r;
  logic              sys_rst_n_r;
  logic              mcd_timeout;
  logic              wr_mon;
  logic              wr_cause;
  logic              running;
  logic              flash_fault;
  logic              pin_ext_low;
  logic              reset_exit;
  logic              holding;
  logic              taking;
  logic              pin_drive_nxt;
  logic [7:0]        cause_nxt;
  logic [7:0]        rd_mux;

  // Address decodes shared by the write and read paths
  function automatic logic rsc_hit_mon(input logic [7:0] addr);
    rsc_hit_mon = (addr == `RSC_ADDR_MON_CTRL);
  endfunction : rsc_hit_mon

  function automatic logic rsc_hit_cause(input logic [7:0] addr);
    rsc_hit_cause = (addr == `RSC_ADDR_CAUSE);
  endfunction : rsc_hit_cause

  // Register writes only land while the core runs
  assign running  = (state_r == rsc_pkg::ST_RUN);
  assign holding  = (state_r == rsc_pkg::ST_HOLD);
  assign wr_mon   = running && sfr_req.wr && rsc_hit_mon(sfr_req.addr);
  assign wr_cause = running && sfr_req.wr && rsc_hit_cause(sfr_req.addr);

  // Last cycle of a hold; selects are dropped here, the monitor select kept after a power-type reset
  assign reset_exit = holding && (state_nxt == rsc_pkg::ST_RUN);

  // Monitor enable: set by power-on, untouched by other resets,
  // so a monitor that software switched off stays off after a restart
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      mon_en_r <= 1'b1;
    else if (wr_mon)
      mon_en_r <= sfr_req.wdata[`RSC_MON_EN_BIT];
  end

  assign supply_monitor_enable = mon_en_r;

  // Settling counter restarts whenever the monitor is off
  // It saturates, so the status bit cannot fall back by wrapping
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      settle_r <= '0;
    else if (!mon_en_r)
      settle_r <= '0;
    else if (!mon_settled)
      settle_r <= settle_r + SET_W'(1);
  end

  assign mon_settled = (settle_r == SET_W'(SETTLE_CYC));

  // Until settled the output reads low, so early selection trips
  // a reset; software should wait before selecting the monitor
  assign mon_ok = mon_en_r && mon_settled && supply_mon_out;

  // Monitor select: kept over a power-type reset, dropped otherwise
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      sel_vdm_r <= 1'b1;
    else if (reset_exit)
      sel_vdm_r <= cause_r[`RSC_CAUSE_POR_BIT];
    else if (wr_cause)
      sel_vdm_r <= sfr_req.wdata[`RSC_CAUSE_POR_BIT];
  end

  // Clock-loss enable, dropped by every reset
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      sel_mcd_r <= 1'b0;
    else if (reset_exit)
      sel_mcd_r <= 1'b0;
    else if (wr_cause)
      sel_mcd_r <= sfr_req.wdata[`RSC_CAUSE_MCD_BIT];
  end

  // Comparator select, dropped by every reset so turn-on chatter after
  // a restart cannot trip it before software selects it again
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      sel_cmp_r <= 1'b0;
    else if (reset_exit)
      sel_cmp_r <= 1'b0;
    else if (wr_cause)
      sel_cmp_r <= sfr_req.wdata[`RSC_CAUSE_CMP_BIT];
  end

  // Stuck-clock one-shot, armed by its select bit
  // The watched level is sampled on clk, so a stall shows as a level
  // that stops changing; any edge restarts the count
  rsc_clock_loss #(
    .LIMIT_CYC (CLK_LOSS_CYC),
    .CNT_W     (LOSS_W)
  ) u_clock_loss (
    .clk       (clk),
    .nrst      (nrst),
    .enable    (sel_mcd_r),
    .clk_level (sys_clk_level),
    .timeout   (mcd_timeout)
  );

  // Any flash access outside user space or behind security
  // Addresses are compared against the top of user space; the security
  // check itself lives outside and arrives as one pulse
  assign flash_fault =
      (flash.wr_valid && flash.wr_enable
       && rsc_pkg::rsc_above_user(flash.wr_addr))
    || (flash.code_rd_valid
       && rsc_pkg::rsc_above_user(flash.code_rd_addr))
    || (flash.fetch_valid
       && rsc_pkg::rsc_above_user(flash.fetch_addr))
    || flash.sec_block;

  // The device's own pull on the pin must not read back as an outside
  // request, or a power-type reset would hold itself for ever; an
  // outside hold that overlaps the pull is caught once the pull ends
  assign pin_ext_low = !rst_pin_i && !pin_drive_r;

  // Request vector; pulses are caught at entry, levels keep it held
  always_comb
  begin
    req.pin   = pin_ext_low;
    req.vdm   = sel_vdm_r && !mon_ok;
    req.clock_loss_detector   = mcd_timeout;
    req.cmp   = sel_cmp_r && !cmp_out;
    req.wdt   = wdt_expire;
    req.flash = running && flash_fault;
    req.sw    = wr_cause && sfr_req.wdata[`RSC_CAUSE_SW_BIT];
  end

  // Levels that must be gone before a hold releases the core; pulses are
  // only remembered, so they cannot stretch a hold
  assign level_req = req.pin || req.vdm || req.cmp;
  assign any_req   = level_req || req.clock_loss_detector || req.wdt
                     || req.flash || req.sw;

  // A request taken while running starts a new reset
  assign taking    = running && any_req;

  // Map the request vector onto cause flag positions
  always_comb
  begin
    req_bits                        = 8'h00;
    req_bits[`RSC_CAUSE_PIN_BIT]    = req.pin;
    req_bits[`RSC_CAUSE_POR_BIT]    = req.vdm;
    req_bits[`RSC_CAUSE_MCD_BIT]    = req.clock_loss_detector;
    req_bits[`RSC_CAUSE_WDT_BIT]    = req.wdt;
    req_bits[`RSC_CAUSE_SW_BIT]     = req.sw;
    req_bits[`RSC_CAUSE_CMP_BIT]    = req.cmp;
    req_bits[`RSC_CAUSE_FLASH_BIT]  = req.flash;
  end

  assign power_cause = cause_r[`RSC_CAUSE_POR_BIT];

  // Minimum hold counter for the merged reset
  // Restarts on each entry, so every reset gets its full hold
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      hold_r <= '0;
    else if (running)
      hold_r <= '0;
    else if (!hold_done)
      hold_r <= hold_r + HOLD_W'(1);
  end

  assign hold_done = (hold_r >= HOLD_W'(HOLD_CYC));

  // Sequencer: power-on hold, run, hold for any request. A request is
  // taken at a running edge; the system reset falls at that edge and
  // stays low for HOLD_CYC + 1 cycles, longer while a level persists.
  // Pulses during a hold do not stretch it, so a source that keeps
  // firing cannot lock the core in reset.
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      // Power-on waits for the hold only; the pin request stays masked by the device's own pull
      rsc_pkg::ST_POR:
        if (hold_done && !req.pin)
          state_nxt = rsc_pkg::ST_RUN;
      rsc_pkg::ST_RUN:
        if (any_req)
          state_nxt = rsc_pkg::ST_HOLD;
      rsc_pkg::ST_HOLD:
        if (hold_done && !level_req)
          state_nxt = rsc_pkg::ST_RUN;
      default:
        state_nxt = rsc_pkg::ST_HOLD;
    endcase
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      state_r <= rsc_pkg::ST_POR;
    else
      state_r <= state_nxt;
  end

  // Next cause flags: whole overwrite at entry so stale causes read 0,
  // merge during a hold so a late source is not lost
  always_comb
  begin
    cause_nxt = cause_r;
    if (taking)
      cause_nxt = req_bits;
    else if (holding)
      cause_nxt = cause_r | req_bits;
  end

  // Cause flags survive system resets; only power-on reinitialises
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      cause_r <= `RSC_CAUSE_RST_VAL;
    else
      cause_r <= cause_nxt;
  end

  // System reset output, low from power-on through every hold
  // Taken from the next state so the output flop never glitches
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      sys_rst_n_r <= 1'b0;
    else
      sys_rst_n_r <= (state_nxt == rsc_pkg::ST_RUN);
  end

  assign sys_rst_n = sys_rst_n_r;

  // Pin pulled low only for power and monitor resets; a monitor drop
  // inside another hold joins the pull one cycle late, which is harmless
  always_comb
  begin
    pin_drive_nxt = pin_drive_r;
    if (state_nxt == rsc_pkg::ST_RUN)
      pin_drive_nxt = 1'b0;
    else if (running)
      pin_drive_nxt = req.vdm;
    else if (holding)
      pin_drive_nxt = pin_drive_r || power_cause;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      pin_drive_r <= 1'b1;
    else
      pin_drive_r <= pin_drive_nxt;
  end

  // Open drain: drive value is always low, enable selects it
  assign rst_pin_o  = 1'b0;
  assign rst_pin_oe = pin_drive_r;

  // Read multiplexer; unmapped addresses return zero
  always_comb
  begin
    rd_mux = 8'h00;
    if (rsc_hit_mon(sfr_req.addr))
      rd_mux = {mon_en_r, mon_ok, 6'h00};
    else if (rsc_hit_cause(sfr_req.addr))
      rd_mux = {1'b0, cause_r[6:0]};
  end

  // Registered read data; holds its value between reads
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      sfr_rdata <= 8'h00;
    else if (sfr_req.rd)
      sfr_rdata <= rd_mux;
  end

  assign reset_cause = cause_r;

endmodule : rsc_top

//--- tb/rsc_properties.sv
// Port-level checks for the reset source controller
`timescale 1ns/10ps
module rsc_properties (
  input wire logic                  clk,            // System clock
  input wire logic                  nrst,           // Power-on reset
  input wire rsc_pkg::rsc_sfr_req_t sfr_req,        // Register access
  input wire logic [7:0]            sfr_rdata,      // Read data
  input wire logic                  rst_pin_i,      // Pin level
  input wire logic                  rst_pin_o,      // Pin value
  input wire logic                  rst_pin_oe,     // Pin enable
  input wire logic                  supply_mon_out, // Monitor out
  input wire logic                  supply_monitor_enable, // Monitor on
  input wire logic                  cmp_out,        // Comparator
  input wire logic                  wdt_expire,     // Watchdog pulse
  input wire rsc_pkg::rsc_flash_t   flash,          // Flash accesses
  input wire logic                  sys_clk_level,  // Watched clock
  input wire logic                  sys_rst_n,      // System reset
  input wire logic [7:0]            reset_cause     // Cause flags
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic fl_bad;
  logic rd_ctl;

  // Any illegal flash access seen this cycle
  assign fl_bad = (flash.wr_valid && flash.wr_enable
                   && flash.wr_addr > 16'h3dff)
                  || (flash.code_rd_valid && flash.code_rd_addr > 16'h3dff)
                  || (flash.fetch_valid && flash.fetch_addr > 16'h3dff)
                  || flash.sec_block;
  assign rd_ctl = sys_rst_n && sfr_req.rd && sfr_req.addr == 8'hff;

  // Reset entered with the given cause flag
  sequence s_cause(int b);
    !sys_rst_n && reset_cause[b];
  endsequence
  // Minimum hold of the merged reset
  sequence s_held;
    !sys_rst_n [*5];
  endsequence

  chk_pin_enter: assert property (
    sys_rst_n && !rst_pin_i |=> s_cause(0))
    else $error("pin low did not enter reset");
  chk_wdt_enter: assert property (
    sys_rst_n && wdt_expire |=> s_cause(3))
    else $error("watchdog did not enter reset");
  chk_sw_enter: assert property (
    sys_rst_n && sfr_req.wr && sfr_req.addr == 8'hef
    && sfr_req.wdata[4] |=> s_cause(4))
    else $error("software write did not enter reset");
  chk_flash_enter: assert property (
    sys_rst_n && fl_bad |=> s_cause(6))
    else $error("flash fault did not enter reset");
  chk_hold_min: assert property (
    $fell(sys_rst_n) |-> s_held)
    else $error("reset held too briefly");
  chk_pin_quiet: assert property (
    !reset_cause[1] |-> !rst_pin_oe)
    else $error("pin driven by internal reset");
  chk_ctrl_read: assert property (
    rd_ctl |=> sfr_rdata[5:0] == 6'h00
    && sfr_rdata[7] == $past(supply_monitor_enable))
    else $error("control read wrong");
  chk_stat_off: assert property (
    rd_ctl && !supply_monitor_enable |=> !sfr_rdata[6])
    else $error("status high while monitor off");
  chk_pin_drive: assert property (
    rst_pin_oe |-> !rst_pin_o && !sys_rst_n)
    else $error("pin driven outside reset");
  chk_cause_hold: assert property (
    sys_rst_n && $past(sys_rst_n) |-> $stable(reset_cause))
    else $error("cause flags changed while running");
endmodule : rsc_properties

//--- tb/rsc_ext_partner.sv
// Pin pull-up, supply supervisor and comparator outside the block
`timescale 1ns/10ps
module rsc_ext_partner (
  input  wire logic ext_hold,       // Outside circuit pulls pin
  input  wire logic supply_ok,      // Supply above threshold
  input  wire logic cmp_high,       // Plus input above minus input
  input  wire logic rst_pin_o,      // Device pin value
  input  wire logic rst_pin_oe,     // Device pin enable
  output logic      rst_pin_i,      // Wire level
  output logic      supply_mon_out, // Monitor output
  output logic      cmp_out         // Comparator output
);
  // Open drain with pull-up: any low driver wins, idle reads high
  assign rst_pin_i = !(ext_hold || (rst_pin_oe && !rst_pin_o));
  assign supply_mon_out = supply_ok;
  assign cmp_out = cmp_high;
endmodule : rsc_ext_partner

//--- tb/rsc_top_tb.sv
// Self-checking bench for the reset source controller
`timescale 1ns/10ps
module rsc_top_tb;
  logic                  clk, nrst, ext_hold, sup_ok, cmp_hi, stuck;
  logic                  rst_pin_i, rst_pin_o, rst_pin_oe, cmp_out;
  logic                  supply_mon_out, mon_en, wdt_expire, sclk;
  logic                  sys_rst_n;
  logic [7:0]            rdata, cause;
  rsc_pkg::rsc_sfr_req_t sfr_req;
  rsc_pkg::rsc_flash_t   flash;
  int                    n_fail = 0, samples_checked = 0, k;

  // Short counts keep the run brief
  rsc_top #(.CLK_LOSS_CYC(20), .SETTLE_CYC(4)) u_dut (
    .clk, .nrst, .sfr_req, .sfr_rdata(rdata), .rst_pin_i, .rst_pin_o,
    .rst_pin_oe, .supply_mon_out, .supply_monitor_enable(mon_en),
    .cmp_out, .wdt_expire, .flash, .sys_clk_level(sclk), .sys_rst_n,
    .reset_cause(cause));
  rsc_ext_partner u_ext (
    .ext_hold, .supply_ok(sup_ok), .cmp_high(cmp_hi), .rst_pin_o,
    .rst_pin_oe, .rst_pin_i, .supply_mon_out, .cmp_out);

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Watched clock toggles each cycle unless a stall is wanted
  always @(posedge clk) sclk <= stuck ? sclk : ~sclk;

  task automatic chk(input logic [7:0] g, input logic [7:0] e,
                     input string m);
    samples_checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) sfr_req <= '{1'b1, 1'b0, a, d};
    @(posedge clk) sfr_req.wr <= 1'b0;
  endtask : wr

  // Read data is registered one cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk) sfr_req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk) sfr_req.rd <= 1'b0;
    #1 chk(rdata, e, "read");
  endtask : rd

  // Waits out one reset, bounded, then reads the cause flags
  task automatic rst_seen(input logic [7:0] e);
    int i;
    int j;
    for (i = 0; i < 99 && sys_rst_n !== 1'b0; i++) @(posedge clk) #1;
    for (j = 0; j < 99 && sys_rst_n !== 1'b1; j++) @(posedge clk) #1;
    if (i == 99 || j == 99)
    begin
      n_fail++;
      $display("wrong value at %0t: reset never cycled", $time);
      test_done();
    end
    rd(8'hef, e);
    chk(cause, e, "cause port");
  endtask : rst_seen

  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : test_done

  initial
  begin
    {nrst, ext_hold, stuck, wdt_expire, sclk} = '0;
    {sup_ok, cmp_hi} = 2'b11;
    sfr_req = '0;
    flash = '0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    rst_seen(8'h02);
    rd(8'hff, 8'hc0);
    wr(8'hef, 8'h10);
    rst_seen(8'h10);
    wr(8'hff, 8'h3f);
    rd(8'hff, 8'h00);
    // Outside circuit holds the pin for a few cycles
    @(posedge clk) ext_hold <= 1'b1;
    repeat (3) @(posedge clk);
    ext_hold <= 1'b0;
    rst_seen(8'h01);
    rd(8'hff, 8'h00);
    wr(8'hff, 8'h80);
    repeat (8) @(posedge clk);
    rd(8'hff, 8'hc0);
    // Selected monitor sees a supply dip and pulls the pin
    wr(8'hef, 8'h02);
    @(posedge clk) sup_ok <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk({6'h00, rst_pin_oe, sys_rst_n}, 8'h02, "dip");
    @(posedge clk) sup_ok <= 1'b1;
    rst_seen(8'h02);
    wr(8'hef, 8'h20);
    @(posedge clk) cmp_hi <= 1'b0;
    repeat (3) @(posedge clk);
    cmp_hi <= 1'b1;
    rst_seen(8'h20);
    // Selects were cleared, so these sources must stay quiet
    @(posedge clk) {cmp_hi, stuck} <= 2'b01;
    repeat (30) @(posedge clk);
    #1 chk({7'h00, sys_rst_n}, 8'h01, "quiet");
    wr(8'hef, 8'h04);
    rst_seen(8'h04);
    @(posedge clk) {cmp_hi, stuck} <= 2'b10;
    @(posedge clk) wdt_expire <= 1'b1;
    @(posedge clk) wdt_expire <= 1'b0;
    rst_seen(8'h08);
    // Near misses: boundary address and write not enabled
    @(posedge clk) flash <= '{1'b1, 1'b0, 16'hffff, 1'b1, 16'h3dff,
                              1'b1, 16'h3dff, 1'b0};
    @(posedge clk) flash <= '0;
    repeat (3) @(posedge clk);
    #1 chk({7'h00, sys_rst_n}, 8'h01, "boundary");
    for (k = 0; k < 4; k++)
    begin
      @(posedge clk) flash <= '{k == 0, 1'b1, 16'h3e00, k == 1, 16'h3e00,
                                k == 2, 16'h3e00, k == 3};
      @(posedge clk) flash <= '0;
      rst_seen(8'h40);
    end
    test_done();
  end
endmodule : rsc_top_tb

bind rsc_top rsc_properties u_chk (
  .clk, .nrst, .sfr_req, .sfr_rdata, .rst_pin_i, .rst_pin_o, .rst_pin_oe,
  .supply_mon_out, .supply_monitor_enable, .cmp_out, .wdt_expire, .flash,
  .sys_clk_level, .sys_rst_n, .reset_cause);
